/* File: aac_regs.sv */
// Control and status register bank of the class-D amplifier sound path
//
// Contract
// - Nine-bit corner code, bits 8:0, reset 0x04
// - Bit 12 defers gain to zero crossing
// - Eight-bit gain code, bits 7:0, reset 0xBD
// - Two-bit de-emphasis select, bits 11:10, reset 00
// - Bit 9 hard mute: 50% PWM output
// - Bit 8 soft mute with raised-cosine ramp
// - Eight-bit power ceiling, bits 7:0, reset 0xBD
// - Status 14: power stage switching
// - Status 13: analog regulator good
// - Status 10:9: amplifier start-up state
// - Status 8: input 2 bit-clock ratio fault
// - Status 7: input 2 frame rate high
// - Status 6: input 2 frame rate low
// - Status 5: input 1 bit-clock ratio fault
// - Status 4: input 1 frame rate high
// - Status 3: input 1 frame rate low
// - Low status bits: protections read 0 active
`timescale 1ns/1ps
module aac_regs
  import aac_pkg::*;
#(
  parameter int RAMP_STEP_CYC = AAC_RAMP_STEP_CYC,
  parameter int PWM_HALF_CYC  = AAC_PWM_HALF_CYC
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  // Register port from the two-wire control bus front end
  input  wire logic [7:0]                 i_reg_addr,
  input  wire logic                       i_reg_wr,
  input  wire logic [15:0]                i_reg_wdata,
  input  wire logic                       i_reg_rd,
  output logic      [15:0]                o_reg_rdata,
  output logic                            o_reg_rvalid,
  // Status sources from the analog and serial-input sections
  input  wire logic                       i_stage_switching,
  input  wire logic                       i_analog_regulator_good,
  input  wire logic [1:0]                 i_output_stage_state,
  input  wire aac_pkg::aac_serial_fault_s i_in1_fault,
  input  wire aac_pkg::aac_serial_fault_s i_in2_fault,
  input  wire logic                       i_overcurrent_pos_active,
  input  wire logic                       i_overcurrent_neg_active,
  input  wire logic                       i_overtemp_active,
  // Zero crossing pulse from the sound datapath
  input  wire logic                       i_zero_cross,
  // Controls to the sound datapath and power stage
  output aac_pkg::aac_ctrl_s              o_ctrl,
  output logic      [7:0]                 o_gain_applied,
  output logic      [7:0]                 o_mute_scale,
  output logic                            o_soft_muted,
  output logic                            o_hard_mute,
  output logic                            o_hard_mute_pwm
);

  // ****************************************************************
  // Local declarations
  // ****************************************************************
  localparam int SYNC_W = 13;
  localparam logic [15:0] PWM_LAST = 16'(PWM_HALF_CYC - 1);

  logic [8:0]   corner_r;
  logic         zc_update_r;
  logic [7:0]   gain_code_r;
  logic [1:0]   deemph_r;
  logic         hard_mute_r;
  logic         soft_mute_r;
  logic [7:0]   ceiling_r;

  logic         gain_pending_r;
  logic [15:0]  pwm_cnt_r;

  logic         wr_highpass;
  logic         wr_gain;
  logic         wr_dml;

  logic [SYNC_W-1:0] stat_raw;
  logic [SYNC_W-1:0] stat_sync;
  logic [15:0]  status_word;
  logic [15:0]  rdata_nxt;

  logic [7:0]   ramp_scale;
  logic         ramp_muted;

  // ****************************************************************
  // Write decode
  // ****************************************************************

  // Status offset is absent here, so a write to it falls through
  assign wr_highpass = i_reg_wr && (i_reg_addr == AAC_ADDR_HIGHPASS);
  assign wr_gain     = i_reg_wr && (i_reg_addr == AAC_ADDR_GAIN);
  assign wr_dml      = i_reg_wr && (i_reg_addr == AAC_ADDR_DML);

  // ****************************************************************
  // High-pass corner register
  // ****************************************************************

  // Only bits 8:0 are stored; upper bits are dropped on write
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      corner_r <= AAC_CORNER_RST;
    end else if (wr_highpass) begin
      corner_r <= i_reg_wdata[AAC_CORNER_MSB:0];
    end
  end

  // ****************************************************************
  // Gain register and zero-cross mode bit
  // ****************************************************************

  // Stored gain code as software last wrote it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gain_code_r <= AAC_GAIN_RST;
      zc_update_r <= AAC_ZC_RST;
    end else if (wr_gain) begin
      gain_code_r <= i_reg_wdata[AAC_GAIN_MSB:0];
      zc_update_r <= i_reg_wdata[AAC_ZC_BIT];
    end
  end

  // Pending flag: a new write wins over a zero crossing in the same
  // cycle, so the fresh code waits for the next crossing
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gain_pending_r <= 1'b0;
    end else if (wr_gain && i_reg_wdata[AAC_ZC_BIT]) begin
      gain_pending_r <= 1'b1;
    end else if (wr_gain || !zc_update_r || i_zero_cross) begin
      gain_pending_r <= 1'b0;
    end
  end

  // Gain in use by the datapath; immediate when deferral is off,
  // otherwise at a crossing, or at once if software drops deferral
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_gain_applied <= AAC_GAIN_RST;
    end else if (wr_gain && !i_reg_wdata[AAC_ZC_BIT]) begin
      o_gain_applied <= i_reg_wdata[AAC_GAIN_MSB:0];
    end else if (gain_pending_r && !wr_gain && (i_zero_cross || !zc_update_r)) begin
      o_gain_applied <= gain_code_r;
    end
  end

  // ****************************************************************
  // De-emphasis, mute and power ceiling register
  // ****************************************************************

  // Reserved bits 15:12 are never stored
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      deemph_r    <= AAC_DEEMPH_RST;
      hard_mute_r <= AAC_HARD_RST;
      soft_mute_r <= AAC_SOFT_RST;
      ceiling_r   <= AAC_CEIL_RST;
    end else if (wr_dml) begin
      deemph_r    <= i_reg_wdata[AAC_DEEMPH_MSB:AAC_DEEMPH_LSB];
      hard_mute_r <= i_reg_wdata[AAC_HARD_MUTE_BIT];
      soft_mute_r <= i_reg_wdata[AAC_SOFT_MUTE_BIT];
      ceiling_r   <= i_reg_wdata[AAC_CEIL_MSB:0];
    end
  end

  // Control bundle to the datapath, one cycle behind the registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl <= '{dc_block_corner_code: AAC_CORNER_RST,
                  deemph_select:        AAC_DEEMPH_RST,
                  hard_mute:            AAC_HARD_RST,
                  soft_mute:            AAC_SOFT_RST,
                  power_ceiling:        AAC_CEIL_RST};
    end else begin
      o_ctrl.dc_block_corner_code <= corner_r;
      o_ctrl.deemph_select        <= deemph_r;
      o_ctrl.hard_mute            <= hard_mute_r;
      o_ctrl.soft_mute            <= soft_mute_r;
      o_ctrl.power_ceiling        <= ceiling_r;
    end
  end

  // ****************************************************************
  // Hard mute: square wave at half duty on the output stage
  // ****************************************************************

  // Counter only runs while muted, so the wave starts low each time
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pwm_cnt_r <= '0;
    end else if (!hard_mute_r || pwm_cnt_r == PWM_LAST) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 16'd1;
    end
  end

  // Equal high and low half periods give the 50% duty cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_hard_mute     <= 1'b0;
      o_hard_mute_pwm <= 1'b0;
    end else begin
      o_hard_mute <= hard_mute_r;
      if (!hard_mute_r) begin
        o_hard_mute_pwm <= 1'b0;
      end else if (pwm_cnt_r == PWM_LAST) begin
        o_hard_mute_pwm <= !o_hard_mute_pwm;
      end
    end
  end

  // ****************************************************************
  // Soft mute ramp
  // ****************************************************************

  // Shaped both ways: down on set, back up on clear
  aac_soft_ramp #(
    .STEP_CYC (RAMP_STEP_CYC)
  ) u_soft_ramp (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_mute    (soft_mute_r),
    .o_scale   (ramp_scale),
    .o_muted   (ramp_muted)
  );

  // Re-registered so top outputs come straight from flops
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mute_scale <= 8'hFF;
      o_soft_muted <= 1'b0;
    end else begin
      o_mute_scale <= ramp_scale;
      o_soft_muted <= ramp_muted;
    end
  end

  // ****************************************************************
  // Status capture
  // ****************************************************************

  // Sources live in other domains; a two-bit state may show one
  // intermediate value during a transition, acceptable for polling
  assign stat_raw = {i_stage_switching,
                     i_analog_regulator_good,
                     i_output_stage_state,
                     i_in2_fault,
                     i_in1_fault,
                     !i_overcurrent_pos_active,
                     !i_overcurrent_neg_active,
                     !i_overtemp_active};

  aac_sync #(
    .WIDTH (SYNC_W)
  ) u_status_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (stat_raw),
    .o_sync    (stat_sync)
  );

  // Assemble the read-only word; reserved 15 and 12:11 read zero
  always_comb begin
    status_word = 16'h0000;
    status_word[AAC_ST_SWITCH_BIT]   = stat_sync[12];
    status_word[AAC_ST_REG_GOOD_BIT] = stat_sync[11];
    status_word[AAC_ST_STATE_MSB:AAC_ST_STATE_LSB] = stat_sync[10:9];
    status_word[AAC_ST_IN2_LSB+2]    = stat_sync[8];
    status_word[AAC_ST_IN2_LSB+1]    = stat_sync[7];
    status_word[AAC_ST_IN2_LSB]      = stat_sync[6];
    status_word[AAC_ST_IN1_LSB+2]    = stat_sync[5];
    status_word[AAC_ST_IN1_LSB+1]    = stat_sync[4];
    status_word[AAC_ST_IN1_LSB]      = stat_sync[3];
    status_word[AAC_ST_OC_POS_BIT]   = stat_sync[2];
    status_word[AAC_ST_OC_NEG_BIT]   = stat_sync[1];
    status_word[AAC_ST_OT_BIT]       = stat_sync[0];
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Reserved bits zero-filled; unknown offsets return zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (i_reg_addr)
      AAC_ADDR_HIGHPASS: rdata_nxt[AAC_CORNER_MSB:0] = corner_r;
      AAC_ADDR_GAIN: begin
        rdata_nxt[AAC_ZC_BIT]       = zc_update_r;
        rdata_nxt[AAC_GAIN_MSB:0]   = gain_code_r;
      end
      AAC_ADDR_DML: begin
        rdata_nxt[AAC_DEEMPH_MSB:AAC_DEEMPH_LSB] = deemph_r;
        rdata_nxt[AAC_HARD_MUTE_BIT] = hard_mute_r;
        rdata_nxt[AAC_SOFT_MUTE_BIT] = soft_mute_r;
        rdata_nxt[AAC_CEIL_MSB:0]    = ceiling_r;
      end
      AAC_ADDR_STATUS:   rdata_nxt = status_word;
      default:           rdata_nxt = 16'h0000;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

endmodule : aac_regs

/* File: aac_pkg.sv */
// Package: register map, field layout, reset values and timing for the amp control bank
package aac_pkg;

  // ****************************************************************
  // Register offsets (byte-wide register address, 16-bit data)
  // ****************************************************************
  localparam logic [7:0] AAC_ADDR_HIGHPASS = 8'h12;
  localparam logic [7:0] AAC_ADDR_GAIN     = 8'h13;
  localparam logic [7:0] AAC_ADDR_DML      = 8'h14;
  localparam logic [7:0] AAC_ADDR_STATUS   = 8'h15;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int AAC_CORNER_MSB      = 8;
  localparam int AAC_ZC_BIT          = 12;
  localparam int AAC_GAIN_MSB        = 7;
  localparam int AAC_DEEMPH_MSB      = 11;
  localparam int AAC_DEEMPH_LSB      = 10;
  localparam int AAC_HARD_MUTE_BIT   = 9;
  localparam int AAC_SOFT_MUTE_BIT   = 8;
  localparam int AAC_CEIL_MSB        = 7;
  localparam int AAC_ST_SWITCH_BIT   = 14;
  localparam int AAC_ST_REG_GOOD_BIT = 13;
  localparam int AAC_ST_STATE_MSB    = 10;
  localparam int AAC_ST_STATE_LSB    = 9;
  localparam int AAC_ST_IN2_LSB      = 6;
  localparam int AAC_ST_IN1_LSB      = 3;
  localparam int AAC_ST_OC_POS_BIT   = 2;
  localparam int AAC_ST_OC_NEG_BIT   = 1;
  localparam int AAC_ST_OT_BIT       = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [8:0] AAC_CORNER_RST  = 9'h004;
  localparam logic       AAC_ZC_RST      = 1'b1;
  localparam logic [7:0] AAC_GAIN_RST    = 8'hBD;
  localparam logic [1:0] AAC_DEEMPH_RST  = 2'h0;
  localparam logic       AAC_HARD_RST    = 1'b0;
  localparam logic       AAC_SOFT_RST    = 1'b0;
  localparam logic [7:0] AAC_CEIL_RST    = 8'hBD;

  // ****************************************************************
  // Timing: clock, soft-mute step, hard-mute PWM half period
  // ****************************************************************
  localparam int AAC_CLK_PERIOD_PS   = 4000;
  localparam int AAC_RAMP_STEP_NS    = 1000;
  localparam int AAC_RAMP_STEP_CYC   = (AAC_RAMP_STEP_NS * 1000) / AAC_CLK_PERIOD_PS;
  localparam int AAC_PWM_HALF_NS     = 1000;
  localparam int AAC_PWM_HALF_CYC    = (AAC_PWM_HALF_NS * 1000) / AAC_CLK_PERIOD_PS;
  localparam int AAC_RAMP_STEPS      = 16;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic bitclk_ratio_fault;
    logic frame_rate_high;
    logic frame_rate_low;
  } aac_serial_fault_s;

  typedef struct packed {
    logic [8:0] dc_block_corner_code;
    logic [1:0] deemph_select;
    logic       hard_mute;
    logic       soft_mute;
    logic [7:0] power_ceiling;
  } aac_ctrl_s;

endpackage : aac_pkg

/* File: aac_sync.sv */
// Two-flop level synchroniser for pin and analog status inputs
`timescale 1ns/1ps
module aac_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : aac_sync

/* File: aac_soft_ramp.sv */
// Raised-cosine soft-mute ramp generator
`timescale 1ns/1ps
module aac_soft_ramp
  import aac_pkg::*;
#(
  parameter int STEP_CYC = AAC_RAMP_STEP_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_mute,
  output logic      [7:0] o_scale,
  output logic            o_muted
);

  // ****************************************************************
  // Raised-cosine table, 17 points from silence to full scale
  // ****************************************************************
  function automatic logic [7:0] aac_cos_lut(input logic [4:0] idx);
    case (idx)
      5'd0:    aac_cos_lut = 8'h00;
      5'd1:    aac_cos_lut = 8'h02;
      5'd2:    aac_cos_lut = 8'h0A;
      5'd3:    aac_cos_lut = 8'h15;
      5'd4:    aac_cos_lut = 8'h25;
      5'd5:    aac_cos_lut = 8'h39;
      5'd6:    aac_cos_lut = 8'h4F;
      5'd7:    aac_cos_lut = 8'h66;
      5'd8:    aac_cos_lut = 8'h80;
      5'd9:    aac_cos_lut = 8'h99;
      5'd10:   aac_cos_lut = 8'hB0;
      5'd11:   aac_cos_lut = 8'hC6;
      5'd12:   aac_cos_lut = 8'hDA;
      5'd13:   aac_cos_lut = 8'hEA;
      5'd14:   aac_cos_lut = 8'hF5;
      5'd15:   aac_cos_lut = 8'hFC;
      default: aac_cos_lut = 8'hFF;
    endcase
  endfunction : aac_cos_lut

  localparam logic [4:0]  POS_FULL = 5'(AAC_RAMP_STEPS);
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

  logic [15:0] tick_cnt_r;
  logic [4:0]  pos_r;
  logic        tick;

  assign tick = (tick_cnt_r == STEP_LAST);

  // Step pacing counter; free running keeps the ramp rate fixed
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'd1;
    end
  end

  // Position walks down to silence on mute, back up when released
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pos_r <= POS_FULL;
    end else if (tick && i_mute && pos_r != 5'd0) begin
      pos_r <= pos_r - 5'd1;
    end else if (tick && !i_mute && pos_r != POS_FULL) begin
      pos_r <= pos_r + 5'd1;
    end
  end

  // Registered shaped scale and silence flag
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_scale <= 8'hFF;
      o_muted <= 1'b0;
    end else begin
      o_scale <= aac_cos_lut(pos_r);
      o_muted <= (pos_r == 5'd0);
    end
  end

endmodule : aac_soft_ramp

/* File: aac_regs_assertions.sv */
// Checker for the amp control register bank, bound to its top module
`timescale 1ns/1ps
module aac_regs_assertions
  import aac_pkg::*;
#(
  parameter int RAMP_STEP_CYC = 4,
  parameter int PWM_HALF_CYC  = 4
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rst,
  input wire logic [7:0]         i_reg_addr,
  input wire logic               i_reg_wr,
  input wire logic [15:0]        i_reg_wdata,
  input wire logic               i_reg_rd,
  input wire logic [15:0]        o_reg_rdata,
  input wire logic               o_reg_rvalid,
  input wire logic               i_zero_cross,
  input wire aac_pkg::aac_ctrl_s o_ctrl,
  input wire logic [7:0]         o_gain_applied,
  input wire logic [7:0]         o_mute_scale,
  input wire logic               o_soft_muted,
  input wire logic               o_hard_mute,
  input wire logic               o_hard_mute_pwm
);
  // ****************************************************************
  // Helper logic and sequences
  // ****************************************************************
  logic [15:0] pwm_run_r;
  // Length of the current high phase of the mute square wave
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) pwm_run_r <= 16'h0000;
    else pwm_run_r <= o_hard_mute_pwm ? pwm_run_r + 16'h0001 : 16'h0000;
  end
  sequence s_hp_wr;
    i_reg_wr && i_reg_addr == AAC_ADDR_HIGHPASS;
  endsequence
  sequence s_dml_wr;
    i_reg_wr && i_reg_addr == AAC_ADDR_DML;
  endsequence
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  rvalid_pulse_a: assert property (i_reg_rd |=> o_reg_rvalid ##1 (!o_reg_rvalid || $past(i_reg_rd)))
    else $error("read valid not a single pulse");
  unmapped_zero_a: assert property (i_reg_rd && (i_reg_addr < 8'h12 || i_reg_addr > 8'h15)
    |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
  reserved_zero_a: assert property (o_reg_rvalid |-> !o_reg_rdata[15])
    else $error("reserved top bit read nonzero");
  corner_wr_a: assert property (s_hp_wr |-> ##2
    o_ctrl.dc_block_corner_code == $past(i_reg_wdata[8:0], 2)) else $error("corner code wrong");
  dml_wr_a: assert property (s_dml_wr |-> ##2 (o_ctrl.power_ceiling == $past(i_reg_wdata[7:0], 2)
    && o_hard_mute == $past(i_reg_wdata[9], 2))) else $error("mute or ceiling wrong");
  gain_now_a: assert property (i_reg_wr && i_reg_addr == AAC_ADDR_GAIN && !i_reg_wdata[12]
    |=> o_gain_applied == $past(i_reg_wdata[7:0])) else $error("gain not applied at once");
  gain_hold_a: assert property ($changed(o_gain_applied) |-> $past(i_zero_cross)
    || $past(i_reg_wr && i_reg_addr == AAC_ADDR_GAIN)) else $error("gain changed without cause");
  pwm_half_a: assert property (pwm_run_r <= PWM_HALF_CYC)
    else $error("mute square wave high too long");
  full_scale_a: assert property (!o_ctrl.soft_mute && o_mute_scale == 8'hFF
    |=> o_mute_scale == 8'hFF) else $error("scale left full without soft mute");
  muted_zero_a: assert property (o_soft_muted |-> o_mute_scale == 8'h00)
    else $error("muted flag with nonzero scale");
endmodule : aac_regs_assertions

bind aac_regs aac_regs_assertions #(.RAMP_STEP_CYC(RAMP_STEP_CYC), .PWM_HALF_CYC(PWM_HALF_CYC))
  u_chk (.*);

/* File: tb.sv */
// Self-checking testbench for the amp control register bank
`timescale 1ns/1ps
module tb;
  import aac_pkg::*;
  logic i_clk_sys, i_rst, wr, rd, sw, rg, zc, ocp, ocn, ot;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [1:0] st;
  aac_serial_fault_s in1, in2;
  aac_ctrl_s ctrl;
  logic rvalid, hm, pwm, smuted, saw;
  logic [7:0] gain, scale;
  int mismatches, tests_run, n_hi;
  aac_regs #(.RAMP_STEP_CYC(4), .PWM_HALF_CYC(4)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_stage_switching(sw),
    .i_analog_regulator_good(rg), .i_output_stage_state(st), .i_in1_fault(in1),
    .i_in2_fault(in2), .i_overcurrent_pos_active(ocp), .i_overcurrent_neg_active(ocn),
    .i_overtemp_active(ot), .i_zero_cross(zc), .o_ctrl(ctrl), .o_gain_applied(gain),
    .o_mute_scale(scale), .o_soft_muted(smuted), .o_hard_mute(hm), .o_hard_mute_pwm(pwm));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask : reg_wr
  // Valid stands one cycle only, so look just after the strobe's edge
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1;
    check("rvalid", {15'h0, rvalid}, 16'h0001);
    d = rdata;
  endtask : reg_rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : wait_cyc
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_and_mask();
    reg_rd(AAC_ADDR_HIGHPASS, q); check("hp rst", q, 16'h0004);
    reg_rd(AAC_ADDR_GAIN, q);     check("gain rst", q, 16'h10BD);
    reg_rd(AAC_ADDR_DML, q);      check("dml rst", q, 16'h00BD);
    reg_wr(AAC_ADDR_HIGHPASS, 16'hFFFF); reg_rd(AAC_ADDR_HIGHPASS, q);
    check("hp mask", q, 16'h01FF);
    reg_wr(AAC_ADDR_DML, 16'hFCFF); reg_rd(AAC_ADDR_DML, q);
    check("dml mask", q, 16'h0CFF);
    check("ctrl", {ctrl.deemph_select, ctrl.power_ceiling}, 16'h03FF);
    reg_wr(AAC_ADDR_DML, 16'h0000);
    reg_rd(8'h16, q); check("unmapped", q, 16'h0000);
    $display("test reset_and_mask done");
  endtask : test_reset_and_mask
  task automatic test_status();
    logic [15:0] pat [4];
    pat = '{16'hFFFF, 16'h0000, 16'hAAAA, 16'h5555};
    foreach (pat[i]) begin
      sw <= pat[i][14]; rg <= pat[i][13]; st <= pat[i][10:9];
      in2 <= pat[i][8:6]; in1 <= pat[i][5:3];
      ocp <= ~pat[i][2]; ocn <= ~pat[i][1]; ot <= ~pat[i][0];
      reg_wr(AAC_ADDR_STATUS, ~pat[i]);
      wait_cyc(4);
      reg_rd(AAC_ADDR_STATUS, q);
      check("status", q, pat[i] & 16'h67FF);
    end
    $display("test status done");
  endtask : test_status
  task automatic test_gain();
    reg_wr(AAC_ADDR_GAIN, 16'h10A0);
    wait_cyc(3); check("gain wait", {8'h0, gain}, 16'h00BD);
    zc <= 1'b1; @(posedge i_clk_sys); zc <= 1'b0;
    wait_cyc(2); check("gain zc", {8'h0, gain}, 16'h00A0);
    reg_wr(AAC_ADDR_GAIN, 16'hEF55);
    wait_cyc(1); check("gain now", {8'h0, gain}, 16'h0055);
    reg_rd(AAC_ADDR_GAIN, q); check("gain read", q, 16'h0055);
    $display("test gain done");
  endtask : test_gain
  task automatic test_mute();
    saw = 1'b0;
    n_hi = 0;
    reg_wr(AAC_ADDR_DML, 16'h0200);
    wait_cyc(2); check("hard mute", {15'h0, hm}, 16'h0001);
    // Sixteen samples span two whole periods of the square wave
    for (int i = 0; i < 16; i++) begin
      wait_cyc(1);
      if (pwm === 1'b1) saw = 1'b1;
      if (pwm === 1'b1) n_hi++;
    end
    check("pwm toggles", {15'h0, saw}, 16'h0001);
    check("pwm duty", n_hi[15:0], 16'h0008);
    reg_wr(AAC_ADDR_DML, 16'h0100);
    wait_cyc(90);
    check("soft muted", {smuted, ctrl.soft_mute, scale}, 16'h0300);
    reg_wr(AAC_ADDR_DML, 16'h0000);
    wait_cyc(90);
    check("soft unmuted", {smuted, hm, pwm, scale}, 16'h00FF);
    $display("test mute done");
  endtask : test_mute
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // Whole run needs well under 1500 cycles
  initial begin
    #(4 * 5000);
    mismatches++;
    stop_test();
  end
  initial begin
    mismatches = 0; tests_run = 0;
    i_rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000; zc = 1'b0;
    sw = 1'b0; rg = 1'b0; st = 2'b00; in1 = '0; in2 = '0; ocp = 1'b0; ocn = 1'b0; ot = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    test_reset_and_mask();
    test_status();
    test_gain();
    test_mute();
    stop_test();
  end
endmodule : tb
